// >>> hw/rbd_defines.svh
`ifndef RBD_DEFINES_SVH
`define RBD_DEFINES_SVH

// ----------------------------------------
// processor-visible offsets
// ----------------------------------------
`define RBD_OFF_FUNC 8'h50
`define RBD_OFF_MBOX_HI 8'h51
`define RBD_OFF_MBOX_LO 8'h52
`define RBD_OFF_DATA 8'h53

// ----------------------------------------
// register-file indices
// ----------------------------------------
`define RBD_RF_SECTOR 3'h0
`define RBD_RF_BUFSIZE 3'h1
`define RBD_RF_CPU_PTR 3'h2
`define RBD_RF_EXT_PTR 3'h3
`define RBD_RF_DSK_START 3'h4
`define RBD_RF_DSK_PTR 3'h5
`define RBD_RF_ENTRIES 6

// ----------------------------------------
// function byte fields and sizes
// ----------------------------------------
`define RBD_FN_OP_MSB 7
`define RBD_FN_OP_LSB 5
`define RBD_FN_STEP_MSB 4
`define RBD_FN_STEP_LSB 3
`define RBD_FN_SEL_MSB 2
`define RBD_FN_SEL_LSB 0
`define RBD_FUNC_RESET 8'h00
`define RBD_EXT_QUEUE_MAX 4'hc
`define RBD_FIFO_DEPTH 16
`define RBD_BYTE_W 8

`endif

// >>> hw/rbd_pkg.sv
package rbd_pkg;

  typedef enum logic [2:0]
  {
    RBD_OP_NOP = 3'b000,
    RBD_OP_INC = 3'b001,
    RBD_OP_LOAD = 3'b010,
    RBD_OP_STORE = 3'b011,
    RBD_OP_CNT_LOAD = 3'b100,
    RBD_OP_RELINK = 3'b101,
    RBD_OP_FETCH = 3'b110,
    RBD_OP_COMMIT = 3'b111
  } rbd_op_t;

  typedef struct packed
  {
    rbd_op_t op;
    logic [1:0] step;
    logic [2:0] sel;
  } rbd_func_t;

  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0] dout;
    logic we_n;
    logic oe_n;
    logic doe_n;
    logic ext_cyc;
  } rbd_ram_t;

endpackage

// >>> hw/rbd_top.sv
`timescale 1ns/1ps
`include "rbd_defines.svh"

// ----------------------------------------
// disk write-data fifo
// ----------------------------------------
module rbd_fifo #(
  parameter int W = 8,
  parameter int D = 16
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module rbd_top
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // processor bus
  input wire logic [7:0] ad_in,
  output logic [7:0] ad_out,
  output logic ad_oe_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ce_n,
  // ring buffer ram
  output logic [15:0] rb_addr,
  input wire logic [7:0] rb_din,
  output logic [7:0] rb_dout,
  output logic rb_doe_n,
  output logic rb_we_n,
  output logic rb_oe_n,
  output logic rb_ext_cyc,
  // external channel
  input wire logic ext_req,
  output logic ext_ack,
  input wire logic ext_inbound,
  input wire logic [1:0] ext_step,
  // microsequencer side
  input wire logic disk_to_buf,
  input wire logic [7:0] dsk_wr_data,
  input wire logic dsk_wr_valid,
  output logic dsk_wr_ready,
  input wire logic dsk_rd_req,
  output logic [7:0] dsk_rd_data,
  output logic dsk_rd_valid,
  input wire logic dsk_func_load,
  input wire logic [7:0] dsk_func_val,
  input wire logic dsk_hk,
  input wire logic dsk_err,
  output logic disk_hold,
  output logic buffer_level_test,
  output logic offset_zero,
  output logic clean_zero
);
  logic [15:0] rf [`RBD_RF_ENTRIES];
  logic [7:0] msg_box_upper_r;
  logic [7:0] msg_box_lower_r;
  logic [7:0] buffer_byte_port_r;
  rbd_pkg::rbd_func_t cpu_func_r;
  rbd_pkg::rbd_func_t dsk_func_r;
  rbd_pkg::rbd_func_t hk_func;
  rbd_pkg::rbd_ram_t ram_r;
  logic [15:0] offset_cnt_r;
  logic [15:0] clean_fill_counter_r;
  logic linked_r;
  logic zf_r;
  logic azf_r;
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  logic [2:0] ctl_s3;
  logic [7:0] ad_s1;
  logic [7:0] ad_s2;
  logic [7:0] ad_s3;
  logic ale_f;
  logic rd_f;
  logic wr_f;
  logic [1:0] req_s;
  logic req_s3;
  logic req_f;
  logic [7:0] cpu_addr_r;
  logic cpu_sel;
  logic wr_evt;
  logic rd_end;
  logic cpu_op_pend_r;
  logic cpu_pend_r;
  logic cpu_is_wr_r;
  logic dsk_rq_pend_r;
  logic [3:0] ext_cnt_r;
  logic ext_post;
  logic fifo_vld;
  logic [7:0] fifo_data;
  logic g_disk;
  logic g_cpu;
  logic g_ext;
  logic hk_go;
  logic [1:0] rd_tag_r;
  logic dsk_err_d;

  // ----------------------------------------
  // alu helpers
  // ----------------------------------------
  function automatic logic [15:0] add_step(input logic [15:0] v, input logic [1:0] code);
    add_step = v + {14'h0000, code} + 16'h0001;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ctl_s1 <= 3'h6;
      ctl_s2 <= 3'h6;
      ctl_s3 <= 3'h6;
      ad_s1 <= 8'h00;
      ad_s2 <= 8'h00;
      ad_s3 <= 8'h00;
      req_s <= 2'h0;
      req_s3 <= 1'b0;
    end
    else
    begin
      ctl_s1 <= {rd_n | ce_n, wr_n | ce_n, ale};
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
      ad_s1 <= ad_in;
      ad_s2 <= ad_s1;
      ad_s3 <= ad_s2;
      req_s <= {req_s[0], ext_req};
      req_s3 <= req_s[1];
    end
  end

  // change accepted only when stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      rd_f <= 1'b1;
      wr_f <= 1'b1;
      ale_f <= 1'b0;
      req_f <= 1'b0;
    end
    else
    begin
      if (ctl_s2[2] == ctl_s3[2])
      begin
        rd_f <= ctl_s3[2];
      end
      if (ctl_s2[1] == ctl_s3[1])
      begin
        wr_f <= ctl_s3[1];
      end
      if (ctl_s2[0] == ctl_s3[0])
      begin
        ale_f <= ctl_s3[0];
      end
      if (req_s[1] == req_s3)
      begin
        req_f <= req_s3;
      end
    end
  end

  assign wr_evt = wr_f && (ctl_s2[1] == ctl_s3[1]) && !ctl_s3[1];
  assign rd_end = !rd_f && (ctl_s2[2] == ctl_s3[2]) && ctl_s3[2];
  // leading edge only; a held request posts once
  assign ext_post = !req_f && (req_s[1] == req_s3) && req_s3
    && !(azf_r && !linked_r);

  // ----------------------------------------
  // processor register port
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cpu_addr_r <= 8'h00;
    end
    else if (ale_f)
    begin
      cpu_addr_r <= ad_s3;
    end
  end

  assign cpu_sel = (cpu_addr_r == `RBD_OFF_MBOX_HI) || (cpu_addr_r == `RBD_OFF_MBOX_LO)
    || (cpu_addr_r == `RBD_OFF_DATA);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ad_out <= 8'h00;
      ad_oe_n <= 1'b1;
    end
    else
    begin
      ad_oe_n <= !(!rd_f && cpu_sel);
      unique case (cpu_addr_r)
        `RBD_OFF_MBOX_HI: ad_out <= msg_box_upper_r;
        `RBD_OFF_MBOX_LO: ad_out <= msg_box_lower_r;
        `RBD_OFF_DATA: ad_out <= buffer_byte_port_r;
        default: ad_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // function registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cpu_func_r <= `RBD_FUNC_RESET;
      dsk_func_r <= `RBD_FUNC_RESET;
      cpu_op_pend_r <= 1'b0;
    end
    else
    begin
      if (wr_evt && cpu_addr_r == `RBD_OFF_FUNC)
      begin
        cpu_func_r <= ad_s3;
      end
      if (dsk_func_load)
      begin
        dsk_func_r <= dsk_func_val;
      end
      // sequencer housekeeping wins; processor op waits until dsk_hk drops
      if (wr_evt && cpu_addr_r == `RBD_OFF_FUNC)
      begin
        cpu_op_pend_r <= 1'b1;
      end
      else if (!dsk_hk)
      begin
        cpu_op_pend_r <= 1'b0;
      end
    end
  end

  assign hk_go = dsk_hk || cpu_op_pend_r;
  assign hk_func = dsk_hk ? dsk_func_r : cpu_func_r;

  // ----------------------------------------
  // request bookkeeping and arbitration
  // ----------------------------------------
  rbd_fifo #(
    .W(`RBD_BYTE_W),
    .D(`RBD_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(dsk_wr_valid),
    .in_ready(dsk_wr_ready),
    .in_data(dsk_wr_data),
    .out_valid(fifo_vld),
    .out_ready(g_disk && disk_to_buf),
    .out_data(fifo_data)
  );

  assign disk_hold = ((rf[`RBD_RF_BUFSIZE] - offset_cnt_r) < rf[`RBD_RF_SECTOR]);
  assign g_disk = !disk_hold && (disk_to_buf ? fifo_vld : dsk_rq_pend_r);
  assign g_cpu = !g_disk && cpu_pend_r;
  assign g_ext = !g_disk && !g_cpu && (ext_cnt_r != 4'h0);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dsk_rq_pend_r <= 1'b0;
      cpu_pend_r <= 1'b0;
      cpu_is_wr_r <= 1'b0;
    end
    else
    begin
      if (dsk_rq_pend_r && g_disk && !disk_to_buf)
      begin
        dsk_rq_pend_r <= 1'b0;
      end
      if (dsk_rd_req)
      begin
        dsk_rq_pend_r <= 1'b1;
      end
      if (g_cpu)
      begin
        cpu_pend_r <= 1'b0;
      end
      if (wr_evt && cpu_addr_r == `RBD_OFF_DATA)
      begin
        cpu_pend_r <= 1'b1;
        cpu_is_wr_r <= 1'b1;
      end
      else if ((rd_end && cpu_addr_r == `RBD_OFF_DATA)
        || (hk_go && hk_func.op == rbd_pkg::RBD_OP_FETCH))
      begin
        cpu_pend_r <= 1'b1;
        cpu_is_wr_r <= 1'b0;
      end
    end
  end

  // posts beyond twelve pending are dropped
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ext_cnt_r <= 4'h0;
    end
    else if (ext_post && ext_cnt_r != `RBD_EXT_QUEUE_MAX)
    begin
      ext_cnt_r <= ext_cnt_r + 4'h1 - {3'h0, g_ext};
    end
    else
    begin
      ext_cnt_r <= ext_cnt_r - {3'h0, g_ext};
    end
  end

  // ----------------------------------------
  // ring buffer cycle
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ram_r <= {16'h0000, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0};
      ext_ack <= 1'b0;
      rd_tag_r <= 2'h0;
    end
    else
    begin
      ext_ack <= g_ext;
      ram_r.we_n <= 1'b1;
      ram_r.oe_n <= 1'b1;
      ram_r.doe_n <= 1'b1;
      ram_r.ext_cyc <= 1'b0;
      rd_tag_r <= 2'h0;
      if (g_disk)
      begin
        ram_r.addr <= rf[`RBD_RF_DSK_PTR];
        ram_r.dout <= fifo_data;
        ram_r.we_n <= !disk_to_buf;
        ram_r.doe_n <= !disk_to_buf;
        ram_r.oe_n <= disk_to_buf;
        rd_tag_r <= disk_to_buf ? 2'h0 : 2'h1;
      end
      else if (g_cpu)
      begin
        ram_r.addr <= rf[`RBD_RF_CPU_PTR];
        ram_r.dout <= buffer_byte_port_r;
        ram_r.we_n <= !cpu_is_wr_r;
        ram_r.doe_n <= !cpu_is_wr_r;
        ram_r.oe_n <= cpu_is_wr_r;
        rd_tag_r <= cpu_is_wr_r ? 2'h0 : 2'h2;
      end
      else if (g_ext)
      begin
        // data moves between ram and host directly; our bus stays off
        ram_r.addr <= rf[`RBD_RF_EXT_PTR];
        ram_r.we_n <= !ext_inbound;
        ram_r.oe_n <= ext_inbound;
        ram_r.ext_cyc <= 1'b1;
      end
    end
  end

  assign rb_addr = ram_r.addr;
  assign rb_dout = ram_r.dout;
  assign rb_we_n = ram_r.we_n;
  assign rb_oe_n = ram_r.oe_n;
  assign rb_doe_n = ram_r.doe_n;
  assign rb_ext_cyc = ram_r.ext_cyc;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dsk_rd_data <= 8'h00;
      dsk_rd_valid <= 1'b0;
    end
    else
    begin
      dsk_rd_valid <= (rd_tag_r == 2'h1);
      if (rd_tag_r == 2'h1)
      begin
        dsk_rd_data <= rb_din;
      end
    end
  end

  // ----------------------------------------
  // mailbox and data port
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      msg_box_upper_r <= 8'h00;
      msg_box_lower_r <= 8'h00;
      buffer_byte_port_r <= 8'h00;
    end
    else
    begin
      if (wr_evt && cpu_addr_r == `RBD_OFF_MBOX_HI)
      begin
        msg_box_upper_r <= ad_s3;
      end
      if (wr_evt && cpu_addr_r == `RBD_OFF_MBOX_LO)
      begin
        msg_box_lower_r <= ad_s3;
      end
      if (hk_go && hk_func.op == rbd_pkg::RBD_OP_STORE && hk_func.sel < 3'h6)
      begin
        {msg_box_upper_r, msg_box_lower_r} <= rf[hk_func.sel];
      end
      if (wr_evt && cpu_addr_r == `RBD_OFF_DATA)
      begin
        buffer_byte_port_r <= ad_s3;
      end
      else if (rd_tag_r == 2'h2)
      begin
        buffer_byte_port_r <= rb_din;
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `RBD_RF_ENTRIES; i++)
      begin
        rf[i] <= 16'h0000;
      end
    end
    else
    begin
      if (g_disk)
      begin
        rf[`RBD_RF_DSK_PTR] <= rf[`RBD_RF_DSK_PTR] + 16'h0001;
      end
      if (g_cpu)
      begin
        rf[`RBD_RF_CPU_PTR] <= add_step(rf[`RBD_RF_CPU_PTR], cpu_func_r.step);
      end
      if (g_ext)
      begin
        rf[`RBD_RF_EXT_PTR] <= add_step(rf[`RBD_RF_EXT_PTR], ext_step);
      end
      if (hk_go && hk_func.sel < 3'h6)
      begin
        if (hk_func.op == rbd_pkg::RBD_OP_INC)
        begin
          rf[hk_func.sel] <= add_step(rf[hk_func.sel], hk_func.step);
        end
        else if (hk_func.op == rbd_pkg::RBD_OP_LOAD)
        begin
          rf[hk_func.sel] <= {msg_box_upper_r, msg_box_lower_r};
        end
      end
      // commit copies the disk pointer into sector start with no check that data is clean; load and inc reach it too
      if (hk_go && hk_func.op == rbd_pkg::RBD_OP_COMMIT)
      begin
        rf[`RBD_RF_DSK_START] <= rf[`RBD_RF_DSK_PTR];
      end
    end
  end

  // ----------------------------------------
  // offset counters
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dsk_err_d <= 1'b0;
      linked_r <= 1'b1;
      offset_cnt_r <= 16'h0000;
      clean_fill_counter_r <= 16'h0000;
      zf_r <= 1'b0;
      azf_r <= 1'b0;
    end
    else
    begin
      dsk_err_d <= dsk_err;
      if (dsk_err && !dsk_err_d)
      begin
        linked_r <= 1'b0;
      end
      if (hk_go && hk_func.op == rbd_pkg::RBD_OP_CNT_LOAD)
      begin
        // loading zero leaves the flags clear
        offset_cnt_r <= {msg_box_upper_r, msg_box_lower_r};
        clean_fill_counter_r <= {msg_box_upper_r, msg_box_lower_r};
        zf_r <= 1'b0;
        azf_r <= 1'b0;
      end
      else if (hk_go && hk_func.op == rbd_pkg::RBD_OP_RELINK)
      begin
        // a host access landing with the relink still counts on both
        clean_fill_counter_r <= offset_cnt_r - {15'h0000, g_ext};
        offset_cnt_r <= offset_cnt_r - {15'h0000, g_ext};
        zf_r <= zf_r || (g_ext && offset_cnt_r == 16'h0001);
        azf_r <= g_ext && offset_cnt_r == 16'h0001;
        linked_r <= 1'b1;
      end
      else if (g_disk)
      begin
        offset_cnt_r <= offset_cnt_r + 16'h0001;
        zf_r <= 1'b0;
        if (linked_r && !(dsk_err && !dsk_err_d))
        begin
          clean_fill_counter_r <= clean_fill_counter_r + 16'h0001;
          azf_r <= 1'b0;
        end
      end
      else if (g_ext)
      begin
        offset_cnt_r <= offset_cnt_r - 16'h0001;
        clean_fill_counter_r <= clean_fill_counter_r - 16'h0001;
        if (offset_cnt_r == 16'h0001)
        begin
          zf_r <= 1'b1;
        end
        if (clean_fill_counter_r == 16'h0001)
        begin
          azf_r <= 1'b1;
        end
      end
    end
  end

  assign offset_zero = zf_r;
  assign clean_zero = azf_r;
  assign buffer_level_test = zf_r | azf_r;
endmodule

// >>> verif/rbd_top_asserts.sv
`timescale 1ns/1ps
module rbd_top_asserts
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // processor strobes
  input wire logic rd_n,
  input wire logic ce_n,
  input wire logic ad_oe_n,
  // ram and host
  input wire logic rb_we_n,
  input wire logic rb_oe_n,
  input wire logic rb_doe_n,
  input wire logic rb_ext_cyc,
  input wire logic ext_req,
  input wire logic ext_ack,
  // flags
  input wire logic buffer_level_test,
  input wire logic offset_zero,
  input wire logic clean_zero
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // posted host requests
  // ----------------------------------------
  // saturates: dropped requests only ever raise the count
  logic [4:0] posted_r;
  logic req_r;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      posted_r <= 5'h00;
      req_r <= 1'b0;
    end
    else
    begin
      req_r <= ext_req;
      if (ext_req && !req_r && !ext_ack && posted_r != 5'h1f)
        posted_r <= posted_r + 5'h01;
      else if (ext_ack && !(ext_req && !req_r))
        posted_r <= posted_r - 5'h01;
    end
  end

  sequence host_served;
    ext_ack && rb_ext_cyc && rb_doe_n;
  endsequence

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_ack_cycle: assert property (ext_ack |-> host_served)
    else $error("host ack without host ram cycle");
  chk_ack_posted: assert property (ext_ack |-> posted_r != 5'h00)
    else $error("host ack with nothing posted");
  chk_doe_own: assert property (!rb_doe_n |-> !rb_we_n && !rb_ext_cyc)
    else $error("ram data driven outside own write");
  chk_we_oe_excl: assert property (!rb_we_n |-> rb_oe_n)
    else $error("ram read and write together");
  chk_oe_after_rd: assert property ($fell(ad_oe_n) |-> !$past(rd_n, 2) && !$past(ce_n, 2))
    else $error("ad bus driven without read");
  chk_idle_quiet: assert property (ce_n [*6] |-> ad_oe_n)
    else $error("ad bus driven while deselected");
  chk_level_or: assert property (buffer_level_test == (offset_zero || clean_zero))
    else $error("level test differs from zero flags");
  chk_zero_dec: assert property ($rose(offset_zero) |-> ext_ack || $past(ext_ack))
    else $error("zero flag set without decrement");
  chk_clean_dec: assert property ($rose(clean_zero) |-> ext_ack || $past(ext_ack))
    else $error("clean zero set without decrement");
endmodule

// >>> verif/rbd_host_model.sv
`timescale 1ns/1ps
module rbd_host_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // bench control
  input wire logic go,
  input wire logic [4:0] burst,
  output logic [7:0] n_ack,
  // host channel
  output logic ext_req,
  input wire logic ext_ack,
  // ring buffer ram
  input wire logic [15:0] rb_addr,
  input wire logic [7:0] rb_dout,
  input wire logic rb_we_n,
  input wire logic rb_oe_n,
  input wire logic rb_doe_n,
  output logic [7:0] rb_din
);
  logic [7:0] mem [0:65535];
  logic [4:0] left;
  logic [1:0] ph;
  logic [7:0] last_r;

  // ----------------------------------------
  // request pulses, two high two low
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      left <= 5'h00;
      ph <= 2'h0;
      ext_req <= 1'b0;
      n_ack <= 8'h00;
    end
    else
    begin
      if (ext_ack)
        n_ack <= n_ack + 8'h01;
      if (go)
      begin
        left <= burst;
        ph <= 2'h0;
      end
      else if (left != 5'h00)
      begin
        ph <= ph + 2'h1;
        ext_req <= ~ph[1];
        if (ph == 2'h3)
          left <= left - 5'h01;
      end
      else
        ext_req <= 1'b0;
    end
  end

  // ----------------------------------------
  // static ram
  // ----------------------------------------
  // asynchronous read: data stands while oe is low; a released bus
  // shows the inverse of the last byte, so a late sample sees no data
  always_ff @(posedge mclk)
  begin
    if (!rb_we_n && !rb_doe_n)
      mem[rb_addr] <= rb_dout;
    if (!nrst)
      last_r <= 8'h00;
    else if (!rb_oe_n)
      last_r <= mem[rb_addr];
  end

  assign rb_din = !rb_oe_n ? mem[rb_addr] : ~last_r;
endmodule

// >>> verif/rbd_top_bench.sv
`timescale 1ns/1ps
`include "rbd_defines.svh"
module rbd_top_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ale = 1'b0, rd_n = 1'b1, wr_n = 1'b1, ce_n = 1'b1;
  logic [7:0] ad_drv = 8'h00, ad_out, dsk_wr_data = 8'h00, dsk_func_val = 8'h00;
  logic [7:0] rb_din, rb_dout, dsk_rd_data, n_ack, a0;
  logic [15:0] rb_addr, pushes = 16'h0000;
  logic ad_oe_n, rb_doe_n, rb_we_n, rb_oe_n, rb_ext_cyc, ext_req, ext_ack;
  logic ext_inbound = 1'b0, disk_to_buf = 1'b1, dsk_wr_valid = 1'b0, dsk_rd_req = 1'b0;
  logic dsk_func_load = 1'b0, dsk_hk = 1'b0, dsk_err = 1'b0, go = 1'b0;
  logic dsk_wr_ready, dsk_rd_valid, disk_hold, buffer_level_test, offset_zero, clean_zero;
  logic [1:0] ext_step = 2'b10;
  logic [4:0] burst = 5'h00;
  int n_errors = 0, tests_run = 0, cyc = 0;
  wire [7:0] ad_in = (ad_oe_n === 1'b0) ? ad_out : ad_drv;

  rbd_top rbd_top_i (.*);
  rbd_host_model rbd_host_model_i (.*);

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask

  // extra idle edge keeps data off the latched address
  task automatic adr(input logic [7:0] a);
    @(posedge mclk);
    ad_drv <= a;
    ale <= 1'b1;
    repeat (4) @(posedge mclk);
    ale <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr(a);
    ad_drv <= d;
    wr_n <= 1'b0;
    ce_n <= 1'b0;
    repeat (4) @(posedge mclk);
    wr_n <= 1'b1;
    ce_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    adr(a);
    rd_n <= 1'b0;
    ce_n <= 1'b0;
    v = 1'b0;
    for (int i = 0; i < 10 && !v; i++)
    begin
      @(negedge mclk);
      v = (ad_oe_n === 1'b0);
    end
    d = ad_out;
    @(posedge mclk);
    rd_n <= 1'b1;
    ce_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  task automatic rx(input logic [7:0] a, input logic [7:0] e, input logic ve);
    logic [7:0] d;
    logic v;
    rd(a, d, v);
    chk("ad drive", {15'h0000, ve}, {15'h0000, v});
    if (ve)
      chk("ad data", {8'h00, e}, {8'h00, d});
  endtask

  task automatic fn(input rbd_pkg::rbd_op_t op, input logic [1:0] s, input logic [2:0] sel);
    wr(`RBD_OFF_FUNC, {op, s, sel});
  endtask

  task automatic ld(input logic [2:0] sel, input logic [15:0] v);
    wr(`RBD_OFF_MBOX_HI, v[15:8]);
    wr(`RBD_OFF_MBOX_LO, v[7:0]);
    fn(rbd_pkg::RBD_OP_LOAD, 2'b00, sel);
  endtask

  task automatic cnt(input logic [15:0] v);
    wr(`RBD_OFF_MBOX_HI, v[15:8]);
    wr(`RBD_OFF_MBOX_LO, v[7:0]);
    fn(rbd_pkg::RBD_OP_CNT_LOAD, 2'b00, 3'h0);
  endtask

  task automatic stc(input logic [2:0] sel, input logic [15:0] e);
    logic [7:0] h, l;
    logic v;
    fn(rbd_pkg::RBD_OP_STORE, 2'b00, sel);
    rd(`RBD_OFF_MBOX_HI, h, v);
    rd(`RBD_OFF_MBOX_LO, l, v);
    chk("regfile", e, {h, l});
  endtask

  task automatic host(input logic [4:0] n, input logic [7:0] e);
    a0 = n_ack;
    @(posedge mclk);
    go <= 1'b1;
    burst <= n;
    @(posedge mclk);
    go <= 1'b0;
    repeat (4 * n + 30) @(posedge mclk);
    chk("host acks", {8'h00, e}, {8'h00, n_ack - a0});
  endtask

  task automatic flags(input logic [2:0] e);
    @(negedge mclk);
    chk("flags", {13'h0000, e}, {13'h0000, offset_zero, clean_zero, buffer_level_test});
  endtask

  // ----------------------------------------
  // disk feed, push count and timeout
  // ----------------------------------------
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    dsk_wr_data <= dsk_wr_data + 8'h01;
    if (dsk_wr_valid && dsk_wr_ready)
      pushes <= pushes + 16'h0001;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    logic [15:0] p;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(`RBD_OFF_MBOX_HI, 8'ha5);
    wr(`RBD_OFF_MBOX_LO, 8'h3c);
    rx(`RBD_OFF_MBOX_HI, 8'ha5, 1'b1);
    rx(`RBD_OFF_MBOX_LO, 8'h3c, 1'b1);
    rx(`RBD_OFF_FUNC, 8'h00, 1'b0);
    rx(8'h60, 8'h00, 1'b0);
    ld(`RBD_RF_CPU_PTR, 16'h0200);
    wr(`RBD_OFF_DATA, 8'h5a);
    chk("ram byte", 16'h005a, {8'h00, rbd_host_model_i.mem[16'h0200]});
    ld(`RBD_RF_CPU_PTR, 16'h0200);
    fn(rbd_pkg::RBD_OP_FETCH, 2'b00, `RBD_RF_CPU_PTR);
    rx(`RBD_OFF_DATA, 8'h5a, 1'b1);
    for (int s = 0; s < 6; s++)
    begin
      ld(3'(s), 16'h1111 * 16'(s + 1));
      stc(3'(s), 16'h1111 * 16'(s + 1));
    end
    for (int k = 0; k < 4; k++)
    begin
      ld(`RBD_RF_CPU_PTR, 16'h00fe);
      fn(rbd_pkg::RBD_OP_INC, 2'(k), `RBD_RF_CPU_PTR);
      stc(`RBD_RF_CPU_PTR, 16'h00ff + 16'(k));
    end
    ld(`RBD_RF_SECTOR, 16'h0010);
    ld(`RBD_RF_BUFSIZE, 16'h0020);
    cnt(16'h0011);
    @(negedge mclk);
    chk("hold", 16'h0001, {15'h0000, disk_hold});
    cnt(16'h0010);
    @(negedge mclk);
    chk("hold", 16'h0000, {15'h0000, disk_hold});
    ld(`RBD_RF_SECTOR, 16'h0000);
    // host channel: fixed op and zero flags
    ld(`RBD_RF_EXT_PTR, 16'h0100);
    cnt(16'h0000);
    flags(3'b000);
    cnt(16'h0005);
    host(5'h05, 8'h05);
    flags(3'b111);
    stc(`RBD_RF_EXT_PTR, 16'h010f);
    // disk starves host; queued requests served after
    cnt(16'h0040);
    ld(`RBD_RF_DSK_PTR, 16'h0040);
    ld(`RBD_RF_DSK_START, 16'h0040);
    p = pushes;
    dsk_wr_valid <= 1'b1;
    host(5'h0e, 8'h00);
    dsk_wr_valid <= 1'b0;
    repeat (60) @(posedge mclk);
    chk("queued acks", 16'h000c, {8'h00, n_ack - a0});
    p = pushes - p;
    stc(`RBD_RF_DSK_PTR, 16'h0040 + p);
    stc(`RBD_RF_DSK_START, 16'h0040);
    fn(rbd_pkg::RBD_OP_COMMIT, 2'b00, 3'h0);
    stc(`RBD_RF_DSK_START, 16'h0040 + p);
    // sequencer function register
    @(posedge mclk);
    dsk_func_val <= {rbd_pkg::RBD_OP_INC, 2'b01, `RBD_RF_DSK_PTR};
    dsk_func_load <= 1'b1;
    @(posedge mclk);
    dsk_func_load <= 1'b0;
    dsk_hk <= 1'b1;
    @(posedge mclk);
    dsk_hk <= 1'b0;
    repeat (4) @(posedge mclk);
    stc(`RBD_RF_DSK_PTR, 16'h0042 + p);
    // read error splits counters until relink
    cnt(16'h0001);
    dsk_err <= 1'b1;
    @(posedge mclk);
    dsk_wr_valid <= 1'b1;
    repeat (2) @(posedge mclk);
    dsk_wr_valid <= 1'b0;
    repeat (10) @(posedge mclk);
    host(5'h01, 8'h01);
    flags(3'b011);
    host(5'h01, 8'h00);
    fn(rbd_pkg::RBD_OP_RELINK, 2'b00, 3'h0);
    flags(3'b000);
    host(5'h02, 8'h02);
    flags(3'b111);
    // buffer-to-disk byte comes back the cycle after its ram read
    disk_to_buf <= 1'b0;
    ld(`RBD_RF_DSK_PTR, 16'h0200);
    dsk_rd_req <= 1'b1;
    @(posedge mclk);
    dsk_rd_req <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("disk byte", 16'h015a, {7'h00, dsk_rd_valid, dsk_rd_data});
    stc(`RBD_RF_DSK_PTR, 16'h0201);
    summarize();
  end
endmodule

bind rbd_top rbd_top_asserts rbd_top_asserts_i (.*);
